// ### rtl/omc_defines.svh
// Constants of the operating-mode control: keys, field positions, sizes.
// Assumes inclusion by bare name from the package and from both ends.
// Function
// - Pin at debug level at startup enters debug
// - Debug overlays normal or test, never exclusive
// - Debug disables the reset pin long timer
// - Debug forces infinite, fully open watchdog window
// - Debug sets bus transceiver active by default
// - Debug exit bit write leaves debug mode
// - Debug pin only entry condition; stays after drop
// - Test mode accepts mirror register writes
// - Power-on reset reloads mirrors from fuses, else default
// - Test entry needs 8 V pin and keys
// - Fuse burning needs an extra key command
// - Supply applied copies burned fuses into mirrors
// - Test mode kept until host commands user mode
// - User mode at reset only with 0 V pin
// - User mode blocks mirror and fuse operations
// - Host exits debug after infinite watchdog setup
`ifndef OMC_DEFINES_SVH
`define OMC_DEFINES_SVH

`define OMC_DATA_W        16
`define OMC_ADDR_W        4
`define OMC_MIRROR_DEPTH  16
`define OMC_MIRROR_DEFAULT 16'h0000
`define OMC_SETTLE_CYCLES 3'h3
`define OMC_TEST_KEY1     16'hA5C3
`define OMC_TEST_KEY2     16'h3C5A
`define OMC_PROG_KEY      16'h9E61
`define OMC_DEBUG_EXIT_REQUEST_BIT  0
`define OMC_ST_USER_BIT   0
`define OMC_ST_TEST_BIT   1
`define OMC_ST_DEBUG_BIT  2
`define OMC_ST_ARMED_BIT  3

`endif

// ### rtl/omc_pkg.sv
// Types shared by both ends of the operating-mode control link.
// Assumes the constants header is on the include path.
`include "omc_defines.svh"
package omc_pkg;
  typedef enum logic [2:0] {
    OMC_OP_WRITE_CFG,
    OMC_OP_KEY,
    OMC_OP_GO_USER,
    OMC_OP_MIRROR_WR,
    OMC_OP_MIRROR_RD,
    OMC_OP_FUSE_PROG,
    OMC_OP_STATUS
  } omc_op_e;
  typedef enum logic [1:0] {OMC_BM_NORMAL, OMC_BM_TEST, OMC_BM_USER} omc_base_e;
  typedef logic [`OMC_DATA_W-1:0] omc_word_t;
  typedef logic [`OMC_ADDR_W-1:0] omc_addr_t;
endpackage

// ### rtl/omc_link_if.sv
// Command link between the host controller and the mode control device.
// Assumes both ends share clock_in; the testbench joins the modports.
`timescale 1ns/1ps
`default_nettype none
interface omc_link_if;
  import omc_pkg::*;
  logic      cmd_valid;
  omc_op_e   cmd_op;
  omc_addr_t cmd_addr;
  omc_word_t cmd_data;
  logic      rsp_valid;
  logic      rsp_ok;
  omc_word_t rsp_data;
  logic      busy;
  modport dev  (input cmd_valid, cmd_op, cmd_addr, cmd_data,
                output rsp_valid, rsp_ok, rsp_data, busy);
  modport host (output cmd_valid, cmd_op, cmd_addr, cmd_data,
                input rsp_valid, rsp_ok, rsp_data, busy);
endinterface
`default_nettype wire

// ### rtl/omc_sync2.sv
// Two-stage synchroniser for pin levels entering the clock domain.
// Assumes the inputs are slow comparator levels; no pulse capture.
`timescale 1ns/1ps
`default_nettype none
module omc_sync2 #(
  parameter int WIDTH = 2
) (
  input  wire logic             clock_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] d_in,
  output var  logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_ff;

  // First stage is read only by the second stage
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      meta_ff <= '0;
      q_out   <= '0;
    end else begin
      meta_ff <= d_in;
      q_out   <= meta_ff;
    end
  end
endmodule // omc_sync2
`default_nettype wire

// ### rtl/omc_device.sv
// Device end: operating-mode control with mirror registers and fuse port.
// Assumes reset_in is the power-on reset, fuse read data follows
// fuse_addr_out in the same cycle, and pins pass the synchroniser.
`timescale 1ns/1ps
`default_nettype none
`include "omc_defines.svh"
module omc_device
  import omc_pkg::*;
#(
  parameter int DEPTH = `OMC_MIRROR_DEPTH
) (
  input  wire logic      clock_in,
  input  wire logic      reset_in,
  omc_link_if.dev        link,
  input  wire logic      debug_pin_5v_in,
  input  wire logic      debug_pin_8v_in,
  input  wire logic      fuse_burned_in,
  input  wire omc_word_t fuse_rd_data_in,
  output var  omc_addr_t fuse_addr_out,
  output var  omc_word_t fuse_wdata_out,
  output var  logic      fuse_prog_out,
  output var  logic      debug_mode_out,
  output var  logic      test_mode_out,
  output var  logic      user_mode_out,
  output var  logic      reset_timer_en_out,
  output var  logic      wdg_infinite_out,
  output var  logic      can_active_default_out
);
  typedef enum {OMC_DS_SETTLE, OMC_DS_LOAD, OMC_DS_RUN, OMC_DS_BURN} omc_dstate_e;

  omc_dstate_e state_ff;
  logic [1:0]  pin_sync;          // [1] = 8 V level, [0] = 5 V level
  logic [2:0]  settle_ff;
  omc_addr_t   walk_ff;
  omc_word_t   mirror_mem [DEPTH];
  logic        debug_ff;
  omc_base_e   base_ff;
  logic        key_stage_ff;
  logic        armed_ff;
  logic        rsp_valid_ff;
  logic        rsp_ok_ff;
  omc_word_t   rsp_data_ff;
  logic        take;
  logic        walk_last;

  omc_sync2 #(.WIDTH(2)) u_pin_sync (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .d_in     ({debug_pin_8v_in, debug_pin_5v_in}),
    .q_out    (pin_sync)
  );

  // A command is taken only while running; during load or burn it is ignored
  assign take      = link.cmd_valid && (state_ff == OMC_DS_RUN);
  assign walk_last = (walk_ff == omc_addr_t'(DEPTH - 1));

  // Sequencer: settle pin pipeline, load mirrors, run, burn fuses
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_ff  <= OMC_DS_SETTLE;
      settle_ff <= '0;
      walk_ff   <= '0;
    end else begin
      case (state_ff)
        OMC_DS_SETTLE: begin
          // Wait until the synchroniser shows the true pin level
          if (settle_ff == `OMC_SETTLE_CYCLES) begin
            state_ff <= OMC_DS_LOAD;
          end else begin
            settle_ff <= settle_ff + 3'h1;
          end
        end
        OMC_DS_LOAD: begin
          walk_ff <= walk_ff + omc_addr_t'(1);
          if (walk_last) begin
            walk_ff  <= '0;
            state_ff <= OMC_DS_RUN;
          end
        end
        OMC_DS_RUN: begin
          if (take && link.cmd_op == OMC_OP_FUSE_PROG && base_ff == OMC_BM_TEST
              && armed_ff) begin
            walk_ff  <= '0;
            state_ff <= OMC_DS_BURN;
          end
        end
        OMC_DS_BURN: begin
          walk_ff <= walk_ff + omc_addr_t'(1);
          if (walk_last) begin
            walk_ff  <= '0;
            state_ff <= OMC_DS_RUN;
          end
        end
        default: state_ff <= OMC_DS_SETTLE;
      endcase
    end
  end

  // Mirror storage: fuse copy at power-on, host writes only in test mode.
  // No reset on the array: every entry is rewritten by the load walk.
  always_ff @(posedge clock_in) begin
    if (state_ff == OMC_DS_LOAD) begin
      mirror_mem[walk_ff] <= fuse_burned_in ? fuse_rd_data_in
                                            : `OMC_MIRROR_DEFAULT;
    end else if (take && link.cmd_op == OMC_OP_MIRROR_WR && base_ff == OMC_BM_TEST) begin
      mirror_mem[link.cmd_addr] <= link.cmd_data;
    end
  end

  // Fuse port: address follows the walk, one program pulse per word
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      fuse_addr_out  <= '0;
      fuse_wdata_out <= '0;
      fuse_prog_out  <= 1'b0;
    end else begin
      fuse_prog_out <= 1'b0;
      if (state_ff == OMC_DS_LOAD) begin
        fuse_addr_out <= walk_ff + omc_addr_t'(1);
      end else if (state_ff == OMC_DS_BURN) begin
        fuse_addr_out  <= walk_ff;
        fuse_wdata_out <= mirror_mem[walk_ff];
        fuse_prog_out  <= 1'b1;
      end else begin
        fuse_addr_out <= '0;
      end
    end
  end

  // Debug overlay flag: set from the pin once, cleared only by the exit bit
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      debug_ff <= 1'b0;
    end else if (state_ff == OMC_DS_SETTLE && settle_ff == `OMC_SETTLE_CYCLES) begin
      debug_ff <= pin_sync[0] | pin_sync[1];
    end else if (take && link.cmd_op == OMC_OP_WRITE_CFG
                 && link.cmd_data[`OMC_DEBUG_EXIT_REQUEST_BIT]) begin
      debug_ff <= 1'b0;
    end
  end

  // Base mode: normal or user from the latched pin, test by key, user by command.
  // The debug flag lives apart so it rides on top of normal or test.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      base_ff <= OMC_BM_USER;
    end else if (state_ff == OMC_DS_SETTLE && settle_ff == `OMC_SETTLE_CYCLES) begin
      base_ff <= (pin_sync == 2'b00) ? OMC_BM_USER : OMC_BM_NORMAL;
    end else if (take && link.cmd_op == OMC_OP_KEY && key_stage_ff
                 && link.cmd_data == `OMC_TEST_KEY2 && pin_sync[1]
                 && base_ff == OMC_BM_NORMAL) begin
      base_ff <= OMC_BM_TEST;
    end else if (take && link.cmd_op == OMC_OP_GO_USER) begin
      base_ff <= OMC_BM_USER;
    end
  end

  // Key sequencer: first key arms stage, any other command breaks it
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      key_stage_ff <= 1'b0;
    end else if (take) begin
      key_stage_ff <= (link.cmd_op == OMC_OP_KEY) && (link.cmd_data == `OMC_TEST_KEY1)
                      && (base_ff == OMC_BM_NORMAL);
    end
  end

  // Burn arming: extra key in test mode, consumed by the burn, lost on user
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      armed_ff <= 1'b0;
    end else if (take) begin
      if (link.cmd_op == OMC_OP_KEY && link.cmd_data == `OMC_PROG_KEY
          && base_ff == OMC_BM_TEST) begin
        armed_ff <= 1'b1;
      end else if (link.cmd_op == OMC_OP_FUSE_PROG || link.cmd_op == OMC_OP_GO_USER) begin
        armed_ff <= 1'b0;
      end
    end
  end

  // Response: one cycle after a taken command, with accept flag and data
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rsp_valid_ff <= 1'b0;
      rsp_ok_ff    <= 1'b0;
      rsp_data_ff  <= '0;
    end else begin
      rsp_valid_ff <= take;
      if (take) begin
        rsp_data_ff <= '0;
        case (link.cmd_op)
          OMC_OP_WRITE_CFG: rsp_ok_ff <= 1'b1;
          OMC_OP_KEY: begin
            if (link.cmd_data == `OMC_TEST_KEY1) begin
              rsp_ok_ff <= (base_ff == OMC_BM_NORMAL);
            end else if (link.cmd_data == `OMC_TEST_KEY2) begin
              rsp_ok_ff <= key_stage_ff && pin_sync[1]
                           && (base_ff == OMC_BM_NORMAL);
            end else if (link.cmd_data == `OMC_PROG_KEY) begin
              rsp_ok_ff <= (base_ff == OMC_BM_TEST);
            end else begin
              rsp_ok_ff <= 1'b0;
            end
          end
          OMC_OP_GO_USER:   rsp_ok_ff <= 1'b1;
          OMC_OP_MIRROR_WR: rsp_ok_ff <= (base_ff == OMC_BM_TEST);
          OMC_OP_MIRROR_RD: begin
            // Reads also stay closed outside test mode
            rsp_ok_ff <= (base_ff == OMC_BM_TEST);
            if (base_ff == OMC_BM_TEST) begin
              rsp_data_ff <= mirror_mem[link.cmd_addr];
            end
          end
          OMC_OP_FUSE_PROG: rsp_ok_ff <= (base_ff == OMC_BM_TEST) && armed_ff;
          OMC_OP_STATUS: begin
            rsp_ok_ff <= 1'b1;
            rsp_data_ff[`OMC_ST_USER_BIT]  <= (base_ff == OMC_BM_USER);
            rsp_data_ff[`OMC_ST_TEST_BIT]  <= (base_ff == OMC_BM_TEST);
            rsp_data_ff[`OMC_ST_DEBUG_BIT] <= debug_ff;
            rsp_data_ff[`OMC_ST_ARMED_BIT] <= armed_ff;
          end
          default: rsp_ok_ff <= 1'b0;
        endcase
      end
    end
  end

  assign link.rsp_valid = rsp_valid_ff;
  assign link.rsp_ok    = rsp_ok_ff;
  assign link.rsp_data  = rsp_data_ff;

  // Busy is the registered state, so the host sees it straight from a flop
  logic busy_ff;
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      busy_ff <= 1'b1;
    end else begin
      busy_ff <= !((state_ff == OMC_DS_LOAD && walk_last) ||
                   (state_ff == OMC_DS_BURN && walk_last) ||
                   (state_ff == OMC_DS_RUN && !(take && link.cmd_op == OMC_OP_FUSE_PROG
                    && base_ff == OMC_BM_TEST && armed_ff)));
    end
  end
  assign link.busy = busy_ff;

  // Mode outputs and the safety relaxations that debug brings
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      debug_mode_out         <= 1'b0;
      test_mode_out          <= 1'b0;
      user_mode_out          <= 1'b0;
      reset_timer_en_out     <= 1'b1;
      wdg_infinite_out       <= 1'b0;
      can_active_default_out <= 1'b0;
    end else begin
      debug_mode_out         <= debug_ff;
      test_mode_out          <= (base_ff == OMC_BM_TEST);
      user_mode_out          <= (base_ff == OMC_BM_USER);
      reset_timer_en_out     <= !debug_ff;
      wdg_infinite_out       <= debug_ff;
      can_active_default_out <= debug_ff;
    end
  end
endmodule // omc_device
`default_nettype wire

// ### rtl/omc_host.sv
// Host end: turns user requests into single link commands and waits.
// Assumes one request at a time; the device answers one cycle after take.
`timescale 1ns/1ps
`default_nettype none
`include "omc_defines.svh"
module omc_host
  import omc_pkg::*;
(
  input  wire logic      clock_in,
  input  wire logic      reset_in,
  omc_link_if.host       link,
  input  wire logic      req_valid_in,
  input  wire omc_op_e   req_op_in,
  input  wire omc_addr_t req_addr_in,
  input  wire omc_word_t req_data_in,
  output var  logic      req_ready_out,
  output var  logic      done_out,
  output var  logic      ok_out,
  output var  omc_word_t rdata_out
);
  typedef enum {OMC_HS_IDLE, OMC_HS_WAIT} omc_hstate_e;

  omc_hstate_e state_ff;
  logic        cmd_valid_ff;
  omc_op_e     cmd_op_ff;
  omc_addr_t   cmd_addr_ff;
  omc_word_t   cmd_data_ff;
  logic        go;

  // Ready is registered, so a request is also gated by the live busy level
  assign go = req_valid_in && req_ready_out && !link.busy;

  // Issue one command, then wait for its answer before the next
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_ff     <= OMC_HS_IDLE;
      cmd_valid_ff <= 1'b0;
      cmd_op_ff    <= OMC_OP_STATUS;
      cmd_addr_ff  <= '0;
      cmd_data_ff  <= '0;
    end else begin
      cmd_valid_ff <= 1'b0;
      case (state_ff)
        OMC_HS_IDLE: begin
          if (go) begin
            cmd_valid_ff <= 1'b1;
            cmd_op_ff    <= req_op_in;
            cmd_addr_ff  <= req_addr_in;
            cmd_data_ff  <= req_data_in;
            state_ff     <= OMC_HS_WAIT;
          end
        end
        OMC_HS_WAIT: begin
          if (link.rsp_valid) begin
            state_ff <= OMC_HS_IDLE;
          end
        end
        default: state_ff <= OMC_HS_IDLE;
      endcase
    end
  end

  assign link.cmd_valid = cmd_valid_ff;
  assign link.cmd_op    = cmd_op_ff;
  assign link.cmd_addr  = cmd_addr_ff;
  assign link.cmd_data  = cmd_data_ff;

  // User-side answer and readiness
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      req_ready_out <= 1'b0;
      done_out      <= 1'b0;
      ok_out        <= 1'b0;
      rdata_out     <= '0;
    end else begin
      req_ready_out <= (state_ff == OMC_HS_IDLE) && !go && !link.rsp_valid
                       && !link.busy;
      done_out      <= link.rsp_valid;
      if (link.rsp_valid) begin
        ok_out    <= link.rsp_ok;
        rdata_out <= link.rsp_data;
      end
    end
  end
endmodule // omc_host
`default_nettype wire

// ### verification/omc_asserts.sv
// Checker for the command link between host end and device end.
// Assumes it sits beside the link interface and sees its signals as inputs.
`timescale 1ns/1ps
`default_nettype none
`include "omc_defines.svh"
module omc_asserts
  import omc_pkg::*;
(
  input  wire logic      clock_in,
  input  wire logic      reset_in,
  input  wire logic      cmd_valid,
  input  wire omc_op_e   cmd_op,
  input  wire omc_addr_t cmd_addr,
  input  wire omc_word_t cmd_data,
  input  wire logic      rsp_valid,
  input  wire logic      rsp_ok,
  input  wire omc_word_t rsp_data,
  input  wire logic      busy
);
  logic take;
  logic answer_ok;
  logic key1_last_ff;
  logic key1_before_ff;
  logic test_ff;
  logic user_ff;
  logic dbg_gone_ff;
  logic armed_ff;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  // A command counts only when the device is out of its busy phase
  assign take      = cmd_valid && !busy;
  assign answer_ok = rsp_valid && rsp_ok;

  // Remember whether the previously taken command was the first key
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      key1_last_ff   <= 1'b0;
      key1_before_ff <= 1'b0;
    end else if (take) begin
      key1_before_ff <= key1_last_ff;
      key1_last_ff   <= (cmd_op == OMC_OP_KEY) && (cmd_data == `OMC_TEST_KEY1);
    end
  end

  // Expected base mode, learnt only from accepted answers
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      test_ff <= 1'b0;
      user_ff <= 1'b0;
    end else if (answer_ok && cmd_op == OMC_OP_GO_USER) begin
      test_ff <= 1'b0;
      user_ff <= 1'b1;
    end else if (answer_ok && cmd_op == OMC_OP_KEY && cmd_data == `OMC_TEST_KEY2) begin
      test_ff <= 1'b1;
    end
  end

  // Debug exit and burn arming; power-on reset clears both
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      dbg_gone_ff <= 1'b0;
      armed_ff    <= 1'b0;
    end else begin
      if (answer_ok && cmd_op == OMC_OP_WRITE_CFG && cmd_data[`OMC_DEBUG_EXIT_REQUEST_BIT])
        dbg_gone_ff <= 1'b1;
      if (answer_ok && cmd_op == OMC_OP_KEY && cmd_data == `OMC_PROG_KEY)
        armed_ff <= 1'b1;
      else if (rsp_valid && cmd_op == OMC_OP_FUSE_PROG)
        armed_ff <= 1'b0;
    end
  end

  property p_answer_next;
    take |=> rsp_valid ##1 !rsp_valid;
  endproperty
  a_answer_next: assert property (p_answer_next) else $error("answer not one pulse");
  property p_no_stray;
    rsp_valid |-> $past(take);
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("answer without command");
  property p_key_order;
    answer_ok && cmd_op == OMC_OP_KEY && cmd_data == `OMC_TEST_KEY2 |-> key1_before_ff;
  endproperty
  a_key_order: assert property (p_key_order) else $error("second key taken out of order");
  property p_test_status;
    rsp_valid && cmd_op == OMC_OP_STATUS |-> rsp_data[`OMC_ST_TEST_BIT] == test_ff;
  endproperty
  a_test_status: assert property (p_test_status) else $error("test flag wrong");
  property p_user_status;
    rsp_valid && cmd_op == OMC_OP_STATUS && user_ff |-> rsp_data[`OMC_ST_USER_BIT];
  endproperty
  a_user_status: assert property (p_user_status) else $error("user flag missing");
  property p_user_blocks;
    rsp_valid && user_ff && cmd_op inside {OMC_OP_MIRROR_WR, OMC_OP_MIRROR_RD, OMC_OP_FUSE_PROG}
      |-> !rsp_ok;
  endproperty
  a_user_blocks: assert property (p_user_blocks) else $error("mirror access in user");
  property p_debug_exit;
    rsp_valid && cmd_op == OMC_OP_STATUS && dbg_gone_ff |-> !rsp_data[`OMC_ST_DEBUG_BIT];
  endproperty
  a_debug_exit: assert property (p_debug_exit) else $error("debug kept after exit");
  property p_burn_armed;
    answer_ok && cmd_op == OMC_OP_FUSE_PROG |-> armed_ff;
  endproperty
  a_burn_armed: assert property (p_burn_armed) else $error("burn without extra key");
  property p_burn_busy;
    answer_ok && cmd_op == OMC_OP_FUSE_PROG |-> busy [*8] ##1 busy [*8];
  endproperty
  a_burn_busy: assert property (p_burn_busy) else $error("busy short during burn");
endmodule // omc_asserts
`default_nettype wire

// ### verification/test_sbc_operating_mode_control.sv
// Testbench joining host end and device end through the link interface.
// Assumes a 10 MHz clock; a small array stands in for the fuse sectors.
`timescale 1ns/1ps
`default_nettype none
`include "omc_defines.svh"
module test_sbc_operating_mode_control;
  import omc_pkg::*;
  typedef struct packed {logic care; logic eok; omc_word_t mask; omc_word_t edata;} omc_note_s;
  logic      clock_in, reset_in, pin5, pin8, burned, req_valid, req_ready, done, ok;
  logic      fuse_prog, dbg_m, test_m, user_m, tmr_en, wdg_inf, can_act;
  omc_op_e   req_op;
  omc_addr_t req_addr, fuse_addr;
  omc_word_t req_data, rdata, fuse_rd, fuse_wdata, lfsr;
  omc_word_t fuse_mem [16];
  omc_word_t shadow [16];
  omc_note_s notes [$];
  omc_note_s note;
  int        bad_count, checked;

  omc_link_if link ();
  omc_host u_omc_host (.clock_in(clock_in), .reset_in(reset_in), .link(link),
    .req_valid_in(req_valid), .req_op_in(req_op), .req_addr_in(req_addr),
    .req_data_in(req_data), .req_ready_out(req_ready), .done_out(done), .ok_out(ok),
    .rdata_out(rdata));
  omc_device u_omc_device (.clock_in(clock_in), .reset_in(reset_in), .link(link),
    .debug_pin_5v_in(pin5), .debug_pin_8v_in(pin8), .fuse_burned_in(burned),
    .fuse_rd_data_in(fuse_rd), .fuse_addr_out(fuse_addr), .fuse_wdata_out(fuse_wdata),
    .fuse_prog_out(fuse_prog), .debug_mode_out(dbg_m), .test_mode_out(test_m),
    .user_mode_out(user_m), .reset_timer_en_out(tmr_en), .wdg_infinite_out(wdg_inf),
    .can_active_default_out(can_act));
  omc_asserts u_omc_asserts (.clock_in(clock_in), .reset_in(reset_in),
    .cmd_valid(link.cmd_valid), .cmd_op(link.cmd_op), .cmd_addr(link.cmd_addr),
    .cmd_data(link.cmd_data), .rsp_valid(link.rsp_valid), .rsp_ok(link.rsp_ok),
    .rsp_data(link.rsp_data), .busy(link.busy));

  // Fuse sectors: read data follows the address, a pulse stores one word
  assign fuse_rd = fuse_mem[fuse_addr];
  always @(posedge clock_in) begin
    if (fuse_prog === 1'b1) fuse_mem[fuse_addr] <= fuse_wdata;
  end

  // Clock at 100 ns period
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  task automatic chk(input omc_word_t exp, input omc_word_t act);
    checked++;
    if (act !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t exp=%h act=%h", $time, exp, act);
    end
  endtask

  task automatic wrap_up();
    $display("Counts: checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic omc_word_t lfsr_next(input omc_word_t v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Compare the mode outputs; debug drives the three relaxed safety flags
  task automatic modes(input logic d, input logic t, input logic u);
    chk({10'h000, d, t, u, !d, d, d}, {10'h000, dbg_m, test_m, user_m, tmr_en, wdg_inf, can_act});
  endtask

  // Power-on reset with pins set first; waits until the host is ready
  task automatic por(input logic p5, input logic p8, input logic fb);
    int n;
    pin5 = p5;
    pin8 = p8;
    burned = fb;
    reset_in = 1'b1;
    repeat (4) @(posedge clock_in);
    #1 reset_in = 1'b0;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(posedge clock_in);
      #1 n++;
    end
    // A load walk that never ends is a counted failure, not a silent skip
    if (req_ready !== 1'b1) chk(16'h0001, 16'h0000);
  endtask

  // One request held across the taking edge; the note goes in first
  task automatic issue(input omc_op_e op, input omc_addr_t a, input omc_word_t d,
                       input logic care, input logic eok, input omc_word_t mask,
                       input omc_word_t edata);
    int n;
    @(posedge clock_in);
    #1 n = 0;
    while (req_ready !== 1'b1 && n < 200) begin
      @(posedge clock_in);
      #1 n++;
    end
    if (req_ready !== 1'b1) chk(16'h0001, 16'h0000);
    notes.push_back('{care, eok, mask, edata});
    req_op = op;
    req_addr = a;
    req_data = d;
    req_valid = 1'b1;
    @(posedge clock_in);
    #1 req_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 10) begin
      @(posedge clock_in);
      #1 n++;
    end
    // A missing answer would leave its note behind and skew later checks
    if (done !== 1'b1) chk(16'h0001, 16'h0000);
  endtask

  // Results are judged against the oldest note when done pulses
  always @(negedge clock_in) begin
    if (done === 1'b1) begin
      if (notes.size() == 0) chk(16'h0000, 16'h0001);
      else begin
        note = notes.pop_front();
        if (note.care) chk({15'h0000, note.eok}, {15'h0000, ok});
        chk(note.edata, rdata & note.mask);
      end
    end
  end

  // Watchdog well past the expected run length
  initial begin
    #2000000;
    bad_count++;
    wrap_up();
  end

  // Main sequence: user start, debug start with test work, burned restart
  initial begin
    reset_in = 1'b1;
    req_valid = 1'b0;
    req_op = OMC_OP_STATUS;
    req_addr = 4'h0;
    req_data = 16'h0000;
    bad_count = 0;
    checked = 0;
    lfsr = 16'h001B;
    for (int i = 0; i < 16; i++) fuse_mem[i] = 16'h0000;
    por(1'b0, 1'b0, 1'b0);
    modes(1'b0, 1'b0, 1'b1);
    pin5 = 1'b1;
    pin8 = 1'b1;
    issue(OMC_OP_KEY, 4'h0, `OMC_TEST_KEY1, 1'b1, 1'b0, 16'h0000, 16'h0000);
    issue(OMC_OP_KEY, 4'h0, `OMC_TEST_KEY2, 1'b1, 1'b0, 16'h0000, 16'h0000);
    modes(1'b0, 1'b0, 1'b1);
    issue(OMC_OP_MIRROR_WR, 4'h0, 16'h1234, 1'b1, 1'b0, 16'h0000, 16'h0000);
    issue(OMC_OP_FUSE_PROG, 4'h0, 16'h0000, 1'b1, 1'b0, 16'h0000, 16'h0000);
    issue(OMC_OP_STATUS, 4'h0, 16'h0000, 1'b1, 1'b1, 16'h000F, 16'h0001);
    por(1'b1, 1'b0, 1'b0);
    modes(1'b1, 1'b0, 1'b0);
    pin5 = 1'b0;
    repeat (4) @(posedge clock_in);
    #1 modes(1'b1, 1'b0, 1'b0);
    issue(OMC_OP_KEY, 4'h0, `OMC_TEST_KEY1, 1'b1, 1'b1, 16'h0000, 16'h0000);
    issue(OMC_OP_KEY, 4'h0, `OMC_TEST_KEY2, 1'b1, 1'b0, 16'h0000, 16'h0000);
    pin5 = 1'b1;
    pin8 = 1'b1;
    issue(OMC_OP_KEY, 4'h0, `OMC_TEST_KEY1, 1'b1, 1'b1, 16'h0000, 16'h0000);
    issue(OMC_OP_STATUS, 4'h0, 16'h0000, 1'b1, 1'b1, 16'h000F, 16'h0004);
    issue(OMC_OP_KEY, 4'h0, `OMC_TEST_KEY2, 1'b1, 1'b0, 16'h0000, 16'h0000);
    issue(OMC_OP_KEY, 4'h0, `OMC_TEST_KEY1, 1'b1, 1'b1, 16'h0000, 16'h0000);
    issue(OMC_OP_KEY, 4'h0, `OMC_TEST_KEY2, 1'b1, 1'b1, 16'h0000, 16'h0000);
    modes(1'b1, 1'b1, 1'b0);
    issue(OMC_OP_MIRROR_RD, 4'h3, 16'h0000, 1'b1, 1'b1, 16'hFFFF, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      shadow[i] = lfsr;
      lfsr = lfsr_next(lfsr);
      issue(OMC_OP_MIRROR_WR, 4'(i), shadow[i], 1'b1, 1'b1, 16'h0000, 16'h0000);
    end
    for (int i = 0; i < 16; i++) begin
      issue(OMC_OP_MIRROR_RD, 4'(i), 16'h0000, 1'b1, 1'b1, 16'hFFFF, shadow[i]);
    end
    pin8 = 1'b0;
    pin5 = 1'b0;
    issue(OMC_OP_WRITE_CFG, 4'h0, 16'h0001, 1'b1, 1'b1, 16'h0000, 16'h0000);
    modes(1'b0, 1'b1, 1'b0);
    issue(OMC_OP_FUSE_PROG, 4'h0, 16'h0000, 1'b1, 1'b0, 16'h0000, 16'h0000);
    issue(OMC_OP_KEY, 4'h0, `OMC_PROG_KEY, 1'b1, 1'b1, 16'h0000, 16'h0000);
    issue(OMC_OP_STATUS, 4'h0, 16'h0000, 1'b1, 1'b1, 16'h000F, 16'h000A);
    issue(OMC_OP_FUSE_PROG, 4'h0, 16'h0000, 1'b1, 1'b1, 16'h0000, 16'h0000);
    repeat (20) @(posedge clock_in);
    #1 for (int i = 0; i < 16; i++) chk(shadow[i], fuse_mem[i]);
    issue(OMC_OP_GO_USER, 4'h0, 16'h0000, 1'b1, 1'b1, 16'h0000, 16'h0000);
    modes(1'b0, 1'b0, 1'b1);
    issue(OMC_OP_STATUS, 4'h0, 16'h0000, 1'b1, 1'b1, 16'h000F, 16'h0001);
    issue(OMC_OP_MIRROR_RD, 4'h0, 16'h0000, 1'b1, 1'b0, 16'h0000, 16'h0000);
    por(1'b1, 1'b1, 1'b1);
    modes(1'b1, 1'b0, 1'b0);
    issue(OMC_OP_KEY, 4'h0, `OMC_TEST_KEY1, 1'b1, 1'b1, 16'h0000, 16'h0000);
    issue(OMC_OP_KEY, 4'h0, `OMC_TEST_KEY2, 1'b1, 1'b1, 16'h0000, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      issue(OMC_OP_MIRROR_RD, 4'(i), 16'h0000, 1'b1, 1'b1, 16'hFFFF, shadow[i]);
    end
    repeat (4) @(posedge clock_in);
    // Every noted request must have been answered by now
    #1 chk(16'h0000, 16'(notes.size()));
    wrap_up();
  end
endmodule // test_sbc_operating_mode_control
`default_nettype wire
